// ==== hdl/ldsc_top.v ====
`timescale 1ns/1ps
`include "ldsc_map.vh"

module ldsc_top #(
    parameter CNT_W        = 20,
    parameter INIT1_CYCLES = (`LDSC_INIT1_US * `LDSC_NS_PER_US + `LDSC_CLK_NS - 1)
                             / `LDSC_CLK_NS,
    parameter INIT2_CYCLES = (`LDSC_INIT2_US * `LDSC_NS_PER_US + `LDSC_CLK_NS - 1)
                             / `LDSC_CLK_NS
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_n_o,
    input  wire       shutoff_pin_i,
    input  wire       adc_done_i,
    input  wire [9:0] adc_code_i,
    output reg        adc_osc_on_o,
    output reg        adc_run_o,
    output reg        adc_rst_o,
    output reg  [2:0] adc_sel_o,
    output reg        pd_dmon_o,
    output reg        bias_dmon_o,
    output reg        tx_ready_o,
    output reg        bias_on_o,
    output reg        out_pos_en_o,
    output reg        out_neg_en_o,
    output reg        nv_reset_o
);

    // ------------------------------------------------------------
    // serial states
    // ------------------------------------------------------------
    localparam ST_IDLE   = 3'h0;
    localparam ST_ADDR   = 3'h1;
    localparam ST_REG    = 3'h2;
    localparam ST_WDATA  = 3'h3;
    localparam ST_RDATA  = 3'h4;
    localparam ST_ACK    = 3'h5;
    localparam ST_IGNORE = 3'h6;

    localparam [CNT_W-1:0] I1_CNT = INIT1_CYCLES[CNT_W-1:0];
    localparam [CNT_W-1:0] I2_CNT = INIT2_CYCLES[CNT_W-1:0];

    reg [1:0]       scl_sync_ff;
    reg [1:0]       sda_sync_ff;
    reg [1:0]       shut_sync_ff;
    reg             scl_d_ff;
    reg             sda_d_ff;
    reg [2:0]       state_ff;
    reg [2:0]       after_ack_ff;
    reg [3:0]       bit_cnt_ff;
    reg [7:0]       shift_ff;
    reg [7:0]       tx_ff;
    reg [7:0]       ptr_ff;
    reg [7:0]       wdata_ff;
    reg             wr_pulse_ff;
    reg             sda_oe_n_ff;
    reg [CNT_W-1:0] por_cnt_ff;
    reg [7:0]       core_ff;
    reg [7:0]       moncfg_ff;
    reg [7:0]       conv_ff;
    reg [7:0]       outmode_ff;
    reg [7:0]       dmon_ff;
    reg [7:0]       res_hi_ff;
    reg [7:0]       res_lo_ff;
    reg             soft_rst_ff;
    reg [7:0]       rd_mux;

    wire            scl_s;
    wire            sda_s;
    wire            scl_rise;
    wire            scl_fall;
    wire            bus_start;
    wire            bus_stop;
    wire            byte_done;
    wire            init1_done;
    wire            init2_done;
    wire            reg_wr;
    wire            regs_rst;
    wire            conv_active;
    wire [7:0]      mem_rd_data;

    // ------------------------------------------------------------
    // pin synchronisers and bus condition detection
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_sync_ff  <= 2'h3;
            sda_sync_ff  <= 2'h3;
            shut_sync_ff <= 2'h0;
            scl_d_ff     <= 1'b1;
            sda_d_ff     <= 1'b1;
        end else begin
            scl_sync_ff  <= {scl_sync_ff[0], scl_i};
            sda_sync_ff  <= {sda_sync_ff[0], sda_i};
            shut_sync_ff <= {shut_sync_ff[0], shutoff_pin_i};
            scl_d_ff     <= scl_sync_ff[1];
            sda_d_ff     <= sda_sync_ff[1];
        end
    end

    assign scl_s     = scl_sync_ff[1];
    assign sda_s     = sda_sync_ff[1];
    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign byte_done = scl_fall & (bit_cnt_ff == `LDSC_BYTE_BITS);

    // ------------------------------------------------------------
    // power-on timing
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            por_cnt_ff <= {CNT_W{1'b0}};
        end else if (por_cnt_ff != I2_CNT) begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
        end
    end

    assign init1_done = (por_cnt_ff >= I1_CNT);
    assign init2_done = (por_cnt_ff == I2_CNT);

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    // slave only: the link is clocked and framed by the master
    always @(posedge clk_i) begin
        wr_pulse_ff <= 1'b0;
        if (rst_i) begin
            state_ff     <= ST_IDLE;
            after_ack_ff <= ST_IDLE;
            bit_cnt_ff   <= 4'h0;
            shift_ff     <= 8'h00;
            tx_ff        <= 8'h00;
            ptr_ff       <= 8'h00;
            wdata_ff     <= 8'h00;
            sda_oe_n_ff  <= 1'b1;
        end else if (bus_start) begin
            state_ff    <= ST_ADDR;
            bit_cnt_ff  <= 4'h0;
            sda_oe_n_ff <= 1'b1;
        end else if (bus_stop) begin
            state_ff    <= ST_IDLE;
            sda_oe_n_ff <= 1'b1;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        if (shift_ff[7:1] == `LDSC_SLAVE_ADDR) begin
                            state_ff     <= ST_ACK;
                            sda_oe_n_ff  <= 1'b0;
                            after_ack_ff <= shift_ff[0] ? ST_RDATA : ST_REG;
                        end else begin
                            state_ff <= ST_IGNORE;
                        end
                    end
                end
                ST_REG: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        ptr_ff       <= shift_ff;
                        state_ff     <= ST_ACK;
                        sda_oe_n_ff  <= 1'b0;
                        after_ack_ff <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        wdata_ff     <= shift_ff;
                        wr_pulse_ff  <= 1'b1;
                        state_ff     <= ST_ACK;
                        sda_oe_n_ff  <= 1'b0;
                        after_ack_ff <= ST_IGNORE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        state_ff   <= after_ack_ff;
                        if (after_ack_ff == ST_RDATA) begin
                            sda_oe_n_ff <= rd_mux[7];
                            tx_ff       <= {rd_mux[6:0], 1'b1};
                        end else begin
                            sda_oe_n_ff <= 1'b1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        sda_oe_n_ff <= 1'b1;
                        state_ff    <= ST_IGNORE;
                    end else if (scl_fall) begin
                        sda_oe_n_ff <= tx_ff[7];
                        tx_ff       <= {tx_ff[6:0], 1'b1};
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_n_ff <= 1'b1;
                end
                default: begin
                    state_ff    <= ST_IDLE;
                    sda_oe_n_ff <= 1'b1;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = sda_oe_n_ff;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    assign reg_wr   = wr_pulse_ff & init1_done;
    assign regs_rst = rst_i | soft_rst_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            soft_rst_ff <= 1'b0;
            nv_reset_o  <= 1'b0;
        end else begin
            soft_rst_ff <= reg_wr & (ptr_ff == `LDSC_REG_CORE)
                           & (wdata_ff[`LDSC_B_GLB_RST] | wdata_ff[`LDSC_B_REG_RST]);
            nv_reset_o  <= reg_wr & (ptr_ff == `LDSC_REG_CORE)
                           & wdata_ff[`LDSC_B_GLB_RST];
        end
    end

    always @(posedge clk_i) begin
        if (regs_rst) begin
            core_ff    <= `LDSC_CORE_RST;
            moncfg_ff  <= `LDSC_ZERO_BYTE;
            conv_ff    <= `LDSC_ZERO_BYTE;
            outmode_ff <= `LDSC_ZERO_BYTE;
            dmon_ff    <= `LDSC_ZERO_BYTE;
            res_hi_ff  <= `LDSC_ZERO_BYTE;
            res_lo_ff  <= `LDSC_ZERO_BYTE;
        end else begin
            if (reg_wr) begin
                case (ptr_ff)
                    `LDSC_REG_CORE:    core_ff    <= wdata_ff & `LDSC_CORE_RWMASK;
                    `LDSC_REG_MONCFG:  moncfg_ff  <= wdata_ff;
                    `LDSC_REG_CONV:    conv_ff    <= wdata_ff;
                    `LDSC_REG_OUTMODE: outmode_ff <= wdata_ff;
                    `LDSC_REG_DMON:    dmon_ff    <= wdata_ff;
                    default:           core_ff    <= core_ff;
                endcase
            end
            if (adc_done_i & conv_active) begin
                res_hi_ff <= adc_code_i[9:2];
                res_lo_ff <= {6'h00, adc_code_i[1:0]};
            end
        end
    end

    ldsc_regfile #(
        .AW (8),
        .DW (8)
    ) u_regfile (
        .clk_i     (clk_i),
        .rst_i     (regs_rst),
        .wr_en_i   (reg_wr),
        .wr_addr_i (ptr_ff),
        .wr_data_i (wdata_ff),
        .rd_addr_i (ptr_ff),
        .rd_data_o (mem_rd_data)
    );

    // self-clearing bits of register zero are never stored, so read zero
    always @* begin
        case (ptr_ff)
            `LDSC_REG_CORE:   rd_mux = core_ff;
            `LDSC_REG_RES_HI: rd_mux = res_hi_ff;
            `LDSC_REG_RES_LO: rd_mux = res_lo_ff;
            default:          rd_mux = mem_rd_data;
        endcase
    end

    // ------------------------------------------------------------
    // converter control and output steering
    // ------------------------------------------------------------
    assign conv_active = conv_ff[`LDSC_B_OSC_ON] & conv_ff[`LDSC_B_CONV_ON]
                         & ~conv_ff[`LDSC_B_CONV_RST];

    always @(posedge clk_i) begin
        if (rst_i) begin
            adc_osc_on_o <= 1'b0;
            adc_run_o    <= 1'b0;
            adc_rst_o    <= 1'b1;
            adc_sel_o    <= 3'h0;
            pd_dmon_o    <= 1'b0;
            bias_dmon_o  <= 1'b0;
            tx_ready_o   <= 1'b0;
            bias_on_o    <= 1'b0;
            out_pos_en_o <= 1'b1;
            out_neg_en_o <= 1'b1;
        end else begin
            adc_osc_on_o <= conv_ff[`LDSC_B_OSC_ON];
            adc_run_o    <= conv_active;
            adc_rst_o    <= conv_ff[`LDSC_B_CONV_RST];
            adc_sel_o    <= conv_ff[`LDSC_SEL_MSB:0];
            pd_dmon_o    <= dmon_ff[`LDSC_B_DMON_PD];
            bias_dmon_o  <= dmon_ff[`LDSC_B_DMON_BIAS];
            tx_ready_o   <= init2_done & core_ff[`LDSC_B_EN_CHIP]
                            & ~shut_sync_ff[1];
            bias_on_o    <= init2_done & core_ff[`LDSC_B_EN_CHIP]
                            & moncfg_ff[`LDSC_B_BIAS_EN] & ~shut_sync_ff[1];
            out_pos_en_o <= ~outmode_ff[`LDSC_B_SINGLE]
                            | ~outmode_ff[`LDSC_B_NEG_OUT];
            out_neg_en_o <= ~outmode_ff[`LDSC_B_SINGLE]
                            | outmode_ff[`LDSC_B_NEG_OUT];
        end
    end

endmodule // ldsc_top

// ==== common/ldsc_map.vh ====
// Function
// - power-up restores register defaults; writes are taken only after the init time
// - transmit ready after init-to-transmit time, chip enable set, shutoff pin low
// - shutoff pin high kills bias, registers kept; low restores prior settings
// - 10-bit converter result: upper eight bits at 40, lower two at 41
// - monitor select: 000 temp, 001 supply, 010 bias, 011 photodiode
// - converter off after reset; runs with oscillator and converter bits set
// - device is slave only; master makes clock, start and stop
// - first byte is slave address 0001000 plus direction bit
// - transaction: start, address byte, register address, one data byte, stop
// - one data byte per start/stop; no burst access
// - idle bus both lines high; start is data fall with clock high
// - stop is data rise with clock high; repeated start also allowed
// - receiver acknowledges by holding data low through acknowledge clock high
// - unaccepted address or extra byte left unacknowledged; master then stops
// - differential by default; single-ended positive, or negative when selected
// - global soft reset bit resets registers and pulses nv_reset_o, self-clears, reads zero
// - register soft reset bit resets registers, self-clears, reads zero
// - register zero resets to 41h; bits 6:3 read/write; bits 7 and 1 self-clear
// - converter reset bit holds the converter in reset while set
`ifndef LDSC_MAP_VH
`define LDSC_MAP_VH

`define LDSC_SLAVE_ADDR  7'h08
`define LDSC_BYTE_BITS   4'h8

`define LDSC_REG_CORE    8'h00
`define LDSC_REG_MONCFG  8'h01
`define LDSC_REG_CONV    8'h03
`define LDSC_REG_OUTMODE 8'h0D
`define LDSC_REG_DMON    8'h10
`define LDSC_REG_RES_HI  8'h28
`define LDSC_REG_RES_LO  8'h29

`define LDSC_CORE_RST    8'h41
`define LDSC_CORE_RWMASK 8'h79
`define LDSC_ZERO_BYTE   8'h00

`define LDSC_B_EN_CHIP   0
`define LDSC_B_REG_RST   1
`define LDSC_B_GLB_RST   7
`define LDSC_B_BIAS_EN   2
`define LDSC_B_CONV_RST  4
`define LDSC_B_OSC_ON    6
`define LDSC_B_CONV_ON   7
`define LDSC_SEL_MSB     2
`define LDSC_B_SINGLE    6
`define LDSC_B_NEG_OUT   7
`define LDSC_B_DMON_PD   6
`define LDSC_B_DMON_BIAS 5

`define LDSC_CLK_NS      20
`define LDSC_INIT1_US    200
`define LDSC_INIT2_US    1000
`define LDSC_NS_PER_US   1000

`endif

// ==== hdl/ldsc_regfile.v ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// register storage, registered read port, clear to zero
// ------------------------------------------------------------
module ldsc_regfile #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [DW-1:0] wr_data_i,
    input  wire [AW-1:0] rd_addr_i,
    output reg  [DW-1:0] rd_data_o
);

    reg [DW-1:0] mem_ff [0:(1<<AW)-1];
    integer      i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem_ff[i] <= {DW{1'b0}};
            end
            rd_data_o <= {DW{1'b0}};
        end else begin
            if (wr_en_i) begin
                mem_ff[wr_addr_i] <= wr_data_i;
            end
            rd_data_o <= mem_ff[rd_addr_i];
        end
    end

endmodule // ldsc_regfile

// ==== verification/ldsc_top_assertions.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checks of the control block
// ------------------------------------------------------------
module ldsc_chk #(
    parameter INIT2_CYCLES = 50000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic shutoff_pin_i,
    input wire logic sda_oe_n_o,
    input wire logic adc_osc_on_o,
    input wire logic adc_run_o,
    input wire logic adc_rst_o,
    input wire logic tx_ready_o,
    input wire logic bias_on_o,
    input wire logic out_pos_en_o,
    input wire logic out_neg_en_o,
    input wire logic nv_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [19:0] init_cnt_ff;
    // cycles since reset release, saturating
    always @(posedge clk_i) begin
        if (rst_i) init_cnt_ff <= 20'h00000;
        else if (init_cnt_ff < INIT2_CYCLES) init_cnt_ff <= init_cnt_ff + 20'h00001;
    end
    property p_rel; $fell(rst_i) |-> sda_oe_n_o && adc_rst_o && !tx_ready_o; endproperty
    a_rel: assert property (p_rel)
        else $error("outputs not at default after reset");
    property p_sda; $changed(sda_oe_n_o) |-> !$past(scl_i); endproperty
    a_sda: assert property (p_sda)
        else $error("data line moved while clock high");
    property p_run; adc_run_o |-> adc_osc_on_o && !adc_rst_o; endproperty
    a_run: assert property (p_run)
        else $error("converter runs without enables");
    property p_tx; tx_ready_o |-> init_cnt_ff >= INIT2_CYCLES - 1; endproperty
    a_tx: assert property (p_tx)
        else $error("transmit ready before init time");
    property p_shut; shutoff_pin_i [*5] |-> !tx_ready_o && !bias_on_o; endproperty
    a_shut: assert property (p_shut)
        else $error("bias on while shutoff high");
    property p_bias; bias_on_o |-> tx_ready_o; endproperty
    a_bias: assert property (p_bias)
        else $error("bias on while not ready");
    property p_outs; out_pos_en_o || out_neg_en_o; endproperty
    a_outs: assert property (p_outs)
        else $error("no output driven");
    property p_nv; nv_reset_o |=> !nv_reset_o; endproperty
    a_nv: assert property (p_nv)
        else $error("global reset pulse too long");
endmodule // ldsc_chk

bind ldsc_top ldsc_chk #(.INIT2_CYCLES(INIT2_CYCLES)) u_chk (
    .clk_i, .rst_i, .scl_i, .shutoff_pin_i, .sda_oe_n_o, .adc_osc_on_o, .adc_run_o,
    .adc_rst_o, .tx_ready_o, .bias_on_o, .out_pos_en_o, .out_neg_en_o, .nv_reset_o
);

// ==== verification/ldsc_i2c_master.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-wire bus master, quarter bit = 2 clocks
// ------------------------------------------------------------
module ldsc_i2c_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // idle bus: both lines released high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic q();
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic start();
        sda_o = 1'b0;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task automatic rstart();
        sda_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        start();
    endtask
    task automatic stop();
        sda_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_o = 1'b1;
        q();
    endtask
    // eight bits msb first then acknowledge; 1 releases the line
    task automatic byte_io(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_o = d[i];
            q();
            scl_o = 1'b1;
            q();
            r[i] = sda_i;
            q();
            scl_o = 1'b0;
            q();
        end
    endtask
endmodule // ldsc_i2c_master

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic       clk_i;
    logic       rst_i;
    logic       shutoff_pin_i;
    logic       adc_done_i;
    logic [9:0] adc_code_i;
    logic       scl;
    logic       m_sda;
    logic       nv_seen = 1'b0;
    wire  logic sda_o, sda_oe_n_o, adc_osc_on_o, adc_run_o, adc_rst_o, pd_dmon_o;
    wire  logic bias_dmon_o, tx_ready_o, bias_on_o, out_pos_en_o, out_neg_en_o;
    wire  logic nv_reset_o;
    wire  logic [2:0] adc_sel_o;
    wire  logic sda = m_sda & (sda_oe_n_o | sda_o);
    int         failures;
    int         cmp_count;
    logic [7:0] om [3] = '{8'h00, 8'h40, 8'hC0};

    ldsc_top #(.INIT1_CYCLES(300), .INIT2_CYCLES(600)) u_dut (
        .clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n_o, .shutoff_pin_i,
        .adc_done_i, .adc_code_i, .adc_osc_on_o, .adc_run_o, .adc_rst_o, .adc_sel_o,
        .pd_dmon_o, .bias_dmon_o, .tx_ready_o, .bias_on_o, .out_pos_en_o,
        .out_neg_en_o, .nv_reset_o
    );
    ldsc_i2c_master u_m (.clk_i, .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (nv_reset_o === 1'b1) nv_seen <= 1'b1;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic pin(input string nm, input logic got, input logic exp);
        chk(nm, {7'h00, got}, {7'h00, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic snd(input logic [7:0] b, input logic nak);
        logic [8:0] r;
        u_m.byte_io({b, 1'b1}, r);
        pin("ack", r[0], nak);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_m.start();
        snd(8'h10, 1'b0);
        snd(a, 1'b0);
        snd(d, 1'b0);
        u_m.stop();
        tick(2);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] r;
        u_m.start();
        snd(8'h10, 1'b0);
        snd(a, 1'b0);
        u_m.rstart();
        snd(8'h11, 1'b0);
        u_m.byte_io(9'h1FF, r);
        u_m.stop();
        chk("rdata", r[8:1], e);
        pin("released", sda_oe_n_o, 1'b1);
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end
    initial begin
        int i;
        rst_i = 1'b1;
        shutoff_pin_i = 1'b0;
        adc_done_i = 1'b0;
        adc_code_i = 10'h000;
        tick(8);
        rst_i = 1'b0;
        tick(2);
        pin("pos", out_pos_en_o, 1'b1);
        pin("neg", out_neg_en_o, 1'b1);
        pin("run", adc_run_o, 1'b0);
        wr(8'h01, 8'h04);
        pin("ready", tx_ready_o, 1'b0);
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h41);
        for (i = 0; i < 1000 && tx_ready_o !== 1'b1; i++) tick(1);
        pin("ready", tx_ready_o, 1'b1);
        if (tx_ready_o !== 1'b1) report_and_stop();
        wr(8'h01, 8'h04);
        pin("bias", bias_on_o, 1'b1);
        shutoff_pin_i = 1'b1;
        tick(10);
        pin("bias", bias_on_o, 1'b0);
        rd(8'h01, 8'h04);
        shutoff_pin_i = 1'b0;
        tick(10);
        pin("bias", bias_on_o, 1'b1);
        for (i = 0; i < 4; i++) begin
            wr(8'h03, 8'hC0 | i[7:0]);
            chk("sel", {5'h00, adc_sel_o}, i[7:0]);
            pin("run", adc_run_o, 1'b1);
        end
        adc_code_i = 10'h2D7;
        adc_done_i = 1'b1;
        tick(1);
        adc_done_i = 1'b0;
        rd(8'h28, 8'hB5);
        rd(8'h29, 8'h03);
        wr(8'h03, 8'hD0);
        pin("conv_rst", adc_rst_o, 1'b1);
        pin("run", adc_run_o, 1'b0);
        wr(8'h03, 8'h40);
        pin("osc", adc_osc_on_o, 1'b1);
        pin("run", adc_run_o, 1'b0);
        for (i = 0; i < 3; i++) begin
            wr(8'h0D, om[i]);
            pin("pos", out_pos_en_o, i < 2);
            pin("neg", out_neg_en_o, i != 1);
        end
        wr(8'h10, 8'h60);
        pin("pd_dmon", pd_dmon_o, 1'b1);
        pin("bias_dmon", bias_dmon_o, 1'b1);
        u_m.start();
        snd(8'h22, 1'b1);
        u_m.stop();
        u_m.start();
        snd(8'h10, 1'b0);
        snd(8'h01, 1'b0);
        snd(8'h06, 1'b0);
        snd(8'h55, 1'b1);
        u_m.stop();
        rd(8'h01, 8'h06);
        rd(8'h02, 8'h00);
        wr(8'h00, 8'h3D);
        rd(8'h00, 8'h39);
        wr(8'h00, 8'h38);
        pin("ready", tx_ready_o, 1'b0);
        wr(8'h00, 8'h02);
        rd(8'h00, 8'h41);
        rd(8'h01, 8'h00);
        wr(8'h01, 8'h04);
        wr(8'h00, 8'h80);
        pin("nv_reset", nv_seen, 1'b1);
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h41);
        report_and_stop();
    end
endmodule // tb_top
